//--- logic/cmm_pkg.sv
// package of constants for the core memory address map block
package cmm_pkg;
    // program side
    localparam int PC_W = 15;
    localparam int PM_AW = 13;
    localparam int PM_WORDS = 8192;
    localparam int PM_DW = 14;
    localparam logic [14:0] RESET_VEC = 15'h0000;
    localparam logic [14:0] INT_VEC = 15'h0004;
    localparam int STACK_DEPTH = 16;
    localparam int STACK_PW = 4;
    // data side
    localparam int DA_W = 12;
    localparam int BANK_W = 5;
    localparam int OFS_W = 7;
    localparam int NUM_BANKS = 32;
    localparam int GPR_BANKS = 13;
    localparam logic [6:0] OFS_INDF0 = 7'h00;
    localparam logic [6:0] OFS_INDF1 = 7'h01;
    localparam logic [6:0] OFS_PCL = 7'h02;
    localparam logic [6:0] OFS_STATUS = 7'h03;
    localparam logic [6:0] OFS_FP0L = 7'h04;
    localparam logic [6:0] OFS_FP0H = 7'h05;
    localparam logic [6:0] OFS_FP1L = 7'h06;
    localparam logic [6:0] OFS_FP1H = 7'h07;
    localparam logic [6:0] OFS_BSR = 7'h08;
    localparam logic [6:0] OFS_WORKING_REGISTER = 7'h09;
    localparam logic [6:0] OFS_PROGRAM_COUNTER_LATCH_HIGH = 7'h0A;
    localparam logic [6:0] OFS_INTCTL = 7'h0B;
    localparam logic [6:0] OFS_SFR_LO = 7'h0C;
    localparam logic [6:0] OFS_SFR_HI = 7'h1F;
    localparam logic [6:0] OFS_GPR_LO = 7'h20;
    localparam logic [6:0] OFS_GPR_HI = 7'h6F;
    localparam logic [6:0] OFS_COM_LO = 7'h70;
    localparam int GPR_PER_BANK = 80;
    localparam int COM_BYTES = 16;
    localparam int GPR_BYTES = 1040;
    localparam int RAM_AW = 11;
    // linear window on the pointer path
    localparam logic [15:0] LIN_BASE = 16'h2000;
    // last byte of the 1040 implemented general bytes; beyond it the ram would alias
    localparam logic [15:0] LIN_TOP = 16'h240F;
    localparam logic [7:0] PTR_HI_RST = 8'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [4:0] BANK_RST = 5'h00;
    typedef enum logic [1:0] {CMM_SRC_DIRECT, CMM_SRC_PTR0, CMM_SRC_PTR1} cmm_src_t;
endpackage

//--- logic/cmm_stack.sv
// return-address stack of sixteen full program counter levels
`timescale 1ns/1ps
module cmm_stack
    import cmm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic push,
    input wire logic pop,
    input wire logic [cmm_pkg::PC_W-1:0] push_val,
    output logic [cmm_pkg::PC_W-1:0] top_val
);
    logic [PC_W-1:0] mem [STACK_DEPTH];
    logic [STACK_PW-1:0] sp_q;
    logic [STACK_PW-1:0] sp_dec;

    // pointer wraps like the hardware; over/underflow is not reported here
    assign sp_dec = sp_q - 4'h1;
    assign top_val = mem[sp_dec];

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            sp_q <= 4'h0;
        end else if (push) begin
            sp_q <= sp_q + 4'h1; // R19
        end else if (pop) begin
            sp_q <= sp_dec; // R19
        end
    end

    // storage carries no reset, only the pointer
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[sp_q] <= push_val;
        end
    end
endmodule

//--- logic/cmm_ram.sv
// byte ram used for banked general and common storage
`timescale 1ns/1ps
module cmm_ram #(
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic clk_sys,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [7:0] rdata
);
    logic [7:0] mem [DEPTH];

    // registered read keeps timing aligned with program memory
    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

//--- logic/cmm_core_memory_map.sv
// address decode and access path for program and data memory of the core
`timescale 1ns/1ps
// Summary of operation
// R1: program counter is fifteen bits, spanning a 32K-word space.
// R2: only 8192 words exist; higher addresses wrap onto them.
// R3: reset starts at 0000h; a taken interrupt jumps to 0004h.
// R4: pointer high byte bit 7 set makes indirect reads hit program memory.
// R5: such a read returns only the low eight bits of the word.
// R6: writes through indirect ports to program memory are dropped.
// R7: pointer access to program memory costs one extra cycle.
// R8: data memory has 32 banks of 128 bytes.
// R9: direct accesses use the bank last written to bank select.
// R10: unimplemented data locations read zero.
// R11: all data reachable directly or through either pointer.
// R12: data addresses are twelve bits, bank above offset.
// R13: first twelve offsets of each bank are the core registers.
// R14: offsets 0Ch to 1Fh of each bank hold peripheral registers.
// R15: up to 80 general bytes per bank after peripherals.
// R16: sixteen common bytes appear identically in every bank.
// R17: general ram is also one linear region via the pointers.
// R18: twelve-bit address splits into 5-bit bank and 7-bit offset.
// R19: stack keeps sixteen full program counters, push on call/interrupt.
module cmm_core_memory_map
    import cmm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic pc_load,
    input wire logic [cmm_pkg::PC_W-1:0] pc_load_val,
    input wire logic pc_step,
    input wire logic int_take,
    input wire logic call_push,
    input wire logic ret_pop,
    input wire logic acc_valid,
    input wire logic acc_write,
    input wire cmm_pkg::cmm_src_t acc_src,
    input wire logic [cmm_pkg::OFS_W-1:0] acc_ofs,
    input wire logic [7:0] acc_wdata,
    input wire logic [cmm_pkg::PM_DW-1:0] pm_rdata,
    input wire logic [7:0] sfr_rdata,
    output logic [cmm_pkg::PC_W-1:0] pc,
    output logic [cmm_pkg::PM_AW-1:0] pm_addr,
    output logic rd_valid,
    output logic [7:0] rd_data,
    output logic stall_cycle,
    output logic sfr_sel,
    output logic sfr_we,
    output logic [cmm_pkg::DA_W-1:0] sfr_addr,
    output logic [7:0] sfr_wdata,
    output logic [cmm_pkg::BANK_W-1:0] bank_select_register,
    output logic [15:0] file_pointer0,
    output logic [15:0] file_pointer1,
    output logic [7:0] working_register
);
    import cmm_pkg::*;

    logic [PC_W-1:0] pc_q;
    logic [BANK_W-1:0] bsr_q;
    logic [7:0] fp0l_q, fp0h_q, fp1l_q, fp1h_q, working_register_q, program_counter_latch_high_q, intctl_q, status_q;
    logic [PC_W-1:0] stk_top;
    logic [PC_W-1:0] pc_d;
    logic rd_prog_q;

    // program counter sequencing; stack return has priority over step
    always_comb begin
        pc_d = pc_q;
        if (int_take) begin
            pc_d = INT_VEC; // R3
        end else if (pc_load) begin
            pc_d = pc_load_val;
        end else if (ret_pop) begin
            pc_d = stk_top;
        end else if (pc_step) begin
            pc_d = pc_q + 15'h0001; // R1
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            pc_q <= RESET_VEC; // R3
        end else begin
            pc_q <= pc_d;
        end
    end

    cmm_stack u_stack (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .push(call_push | int_take), // R19
        .pop(ret_pop && !int_take),
        .push_val(int_take ? pc_q : pc_q + 15'h0001),
        .top_val(stk_top)
    );

    // decode of the effective address
    wire [15:0] fp_sel = (acc_src == CMM_SRC_PTR1) ? {fp1h_q, fp1l_q} : {fp0h_q, fp0l_q};
    wire is_ptr = (acc_src != CMM_SRC_DIRECT); // R11
    wire ptr_prog = is_ptr && fp_sel[15]; // R4
    wire ptr_lin = is_ptr && !fp_sel[15] && (fp_sel >= LIN_BASE) && (fp_sel <= LIN_TOP);
    wire [15:0] lin_idx = fp_sel - LIN_BASE; // R17
    wire [DA_W-1:0] dir_addr = {bsr_q, acc_ofs}; // R9 R12
    wire [DA_W-1:0] eff_addr = is_ptr ? fp_sel[DA_W-1:0] : dir_addr; // R11
    wire [BANK_W-1:0] eff_bank = eff_addr[DA_W-1:OFS_W]; // R8 R18
    wire [OFS_W-1:0] eff_ofs = eff_addr[OFS_W-1:0]; // R18
    wire in_core = !ptr_lin && (eff_ofs < OFS_SFR_LO); // R13
    wire in_sfr = !ptr_lin && (eff_ofs >= OFS_SFR_LO) && (eff_ofs <= OFS_SFR_HI); // R14
    wire in_gpr_ofs = (eff_ofs >= OFS_GPR_LO) && (eff_ofs <= OFS_GPR_HI);
    wire gpr_impl = in_gpr_ofs && ({27'h0, eff_bank} < GPR_BANKS); // R15 R10
    wire in_com = !ptr_lin && (eff_ofs >= OFS_COM_LO); // R16
    wire [10:0] gpr_bank_idx = 11'(eff_bank) * 11'd80 + 11'(eff_ofs - OFS_GPR_LO);
    wire [10:0] gpr_idx = ptr_lin ? lin_idx[10:0] : gpr_bank_idx; // R17
    wire gpr_hit = ptr_lin || (!ptr_prog && gpr_impl);
    wire data_acc = acc_valid && !ptr_prog;
    wire gpr_we = data_acc && acc_write && gpr_hit;
    wire com_we = data_acc && acc_write && in_com && !ptr_prog;

    logic [7:0] gpr_rd, com_rd;
    cmm_ram #(.DEPTH(GPR_BYTES), .AW(RAM_AW)) u_gpr (
        .clk_sys(clk_sys),
        .we(gpr_we), // R15
        .waddr(gpr_idx),
        .wdata(acc_wdata),
        .raddr(gpr_idx),
        .rdata(gpr_rd)
    );
    cmm_ram #(.DEPTH(COM_BYTES), .AW(4)) u_com (
        .clk_sys(clk_sys),
        .we(com_we), // R16
        .waddr(eff_ofs[3:0]),
        .wdata(acc_wdata),
        .raddr(eff_ofs[3:0]),
        .rdata(com_rd)
    );

    // core register read mux; indirect ports read themselves as zero
    logic [7:0] core_rd;
    always_comb begin
        unique case (eff_ofs[3:0])
            4'h2: core_rd = pc_q[7:0];
            4'h3: core_rd = status_q;
            4'h4: core_rd = fp0l_q;
            4'h5: core_rd = fp0h_q;
            4'h6: core_rd = fp1l_q;
            4'h7: core_rd = fp1h_q;
            4'h8: core_rd = {3'h0, bsr_q};
            4'h9: core_rd = working_register_q;
            4'hA: core_rd = program_counter_latch_high_q;
            4'hB: core_rd = intctl_q;
            default: core_rd = 8'h00;
        endcase
    end

    // core register writes from direct or pointer accesses
    wire core_we = data_acc && acc_write && in_core; // R13
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            bsr_q <= BANK_RST;
            fp0l_q <= BYTE_RST;
            fp0h_q <= PTR_HI_RST;
            fp1l_q <= BYTE_RST;
            fp1h_q <= PTR_HI_RST;
            working_register_q <= BYTE_RST;
            program_counter_latch_high_q <= BYTE_RST;
            intctl_q <= BYTE_RST;
            status_q <= BYTE_RST;
        end else if (core_we) begin
            unique case (eff_ofs[3:0])
                4'h3: status_q <= acc_wdata;
                4'h4: fp0l_q <= acc_wdata;
                4'h5: fp0h_q <= acc_wdata;
                4'h6: fp1l_q <= acc_wdata;
                4'h7: fp1h_q <= acc_wdata;
                4'h8: bsr_q <= acc_wdata[BANK_W-1:0]; // R9
                4'h9: working_register_q <= acc_wdata;
                4'hA: program_counter_latch_high_q <= acc_wdata;
                4'hB: intctl_q <= acc_wdata;
                default: ;
            endcase
        end else if (rd_prog_q) begin
            working_register_q <= pm_rdata[7:0]; // R5
        end
    end

    // program-memory read occupies an added cycle; write is dropped
    logic rd_data_q;
    logic rd_core_q, rd_sfr_q, rd_gpr_q, rd_com_q;
    logic [7:0] core_rd_q;
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            rd_prog_q <= 1'b0;
            rd_data_q <= 1'b0;
            rd_core_q <= 1'b0;
            rd_sfr_q <= 1'b0;
            rd_gpr_q <= 1'b0;
            rd_com_q <= 1'b0;
            core_rd_q <= BYTE_RST;
        end else begin
            rd_prog_q <= acc_valid && !acc_write && ptr_prog && !rd_prog_q; // R4 R6 R7
            rd_data_q <= data_acc && !acc_write;
            rd_core_q <= in_core;
            rd_sfr_q <= in_sfr;
            rd_gpr_q <= gpr_hit;
            rd_com_q <= in_com;
            core_rd_q <= core_rd;
        end
    end

    // answer mux; anything unimplemented gives zero
    wire [7:0] data_ans = rd_core_q ? core_rd_q :
                          rd_sfr_q ? sfr_rdata :
                          rd_gpr_q ? gpr_rd :
                          rd_com_q ? com_rd : 8'h00; // R10
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            rd_valid <= 1'b0;
            rd_data <= BYTE_RST;
            stall_cycle <= 1'b0;
        end else begin
            rd_valid <= rd_prog_q || rd_data_q;
            rd_data <= rd_prog_q ? pm_rdata[7:0] : data_ans; // R5
            stall_cycle <= acc_valid && ptr_prog && !rd_prog_q; // R7
        end
    end

    // peripheral and program-address outputs, registered
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            sfr_sel <= 1'b0;
            sfr_we <= 1'b0;
            sfr_addr <= 12'h000;
            sfr_wdata <= BYTE_RST;
            pm_addr <= 13'h0000;
        end else begin
            sfr_sel <= data_acc && in_sfr; // R14
            sfr_we <= data_acc && acc_write && in_sfr;
            sfr_addr <= eff_addr;
            sfr_wdata <= acc_wdata;
            pm_addr <= ptr_prog ? fp_sel[PM_AW-1:0] : pc_d[PM_AW-1:0]; // R2
        end
    end

    assign pc = pc_q;
    assign bank_select_register = bsr_q;
    assign file_pointer0 = {fp0h_q, fp0l_q};
    assign file_pointer1 = {fp1h_q, fp1l_q};
    assign working_register = working_register_q;

    // assertions
    AST_RESET_VEC: assert property (@(posedge clk_sys) !nrst |=> pc == 15'h0000) // R3
        else $error("pc not at reset vector");
    AST_INT_VEC: assert property (@(posedge clk_sys) disable iff (!nrst)
        int_take |=> pc == 15'h0004) // R3
        else $error("interrupt vector wrong");
    AST_WRAP: assert property (@(posedge clk_sys) disable iff (!nrst)
        !ptr_prog |=> pm_addr == $past(pc_d[12:0])) // R2
        else $error("program address not wrapped");
    AST_PROG_LOW: assert property (@(posedge clk_sys) disable iff (!nrst)
        rd_prog_q |=> rd_valid && rd_data == $past(pm_rdata[7:0])) // R5
        else $error("program read not low byte");
    AST_NO_PWRITE: assert property (@(posedge clk_sys) disable iff (!nrst)
        acc_valid && acc_write && ptr_prog |=> !sfr_we && !rd_prog_q) // R6
        else $error("program write not ignored");
    AST_EXTRA: assert property (@(posedge clk_sys) disable iff (!nrst)
        acc_valid && !acc_write && ptr_prog && !rd_prog_q |=> stall_cycle ##1 rd_valid) // R7
        else $error("extra cycle missing");
    AST_BANK: assert property (@(posedge clk_sys) disable iff (!nrst)
        acc_valid && acc_write && !is_ptr && acc_ofs == 7'h08 |=> bsr_q == $past(acc_wdata[4:0])) // R9
        else $error("bank select not updated");
    AST_SFR: assert property (@(posedge clk_sys) disable iff (!nrst)
        data_acc && eff_ofs >= 7'h0C && eff_ofs <= 7'h1F && !ptr_lin |=> sfr_sel) // R14
        else $error("peripheral range not decoded");
    AST_UNIMP: assert property (@(posedge clk_sys) disable iff (!nrst)
        data_acc && !acc_write && !is_ptr && bsr_q >= 5'd13 && acc_ofs >= 7'h20
        && acc_ofs <= 7'h6F |=> ##1 rd_data == 8'h00) // R10
        else $error("unimplemented read not zero");
endmodule

//--- test/cmm_mem_model.sv
// far-side stand-in: program memory words and peripheral register answers
`timescale 1ns/1ps
module cmm_mem_model
    import cmm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [cmm_pkg::PM_AW-1:0] pm_addr,
    input wire logic sfr_sel,
    input wire logic sfr_we,
    input wire logic [cmm_pkg::DA_W-1:0] sfr_addr,
    output logic [cmm_pkg::PM_DW-1:0] pm_rdata,
    output logic [7:0] sfr_rdata
);
    // word scrambled from its address so a wrong address cannot match
    assign pm_rdata = {1'b1, pm_addr} ^ 14'h15A5;
    logic [7:0] idle_q;
    // answer stands while the select does; otherwise the bus flips so stale data never passes
    assign sfr_rdata = (sfr_sel && !sfr_we) ? (sfr_addr[7:0] ^ 8'h5A) : idle_q;
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            idle_q <= 8'h00;
        end else begin
            idle_q <= ~idle_q;
        end
    end
endmodule

//--- test/cmm_core_memory_map_tb.sv
// self-checking bench for the core memory address map
`timescale 1ns/1ps
module cmm_core_memory_map_tb;
    import cmm_pkg::*;
    logic clk_sys, nrst, pc_load, pc_step, int_take, call_push, ret_pop;
    logic acc_valid, acc_write, rd_valid, stall_cycle, sfr_sel, sfr_we, st;
    cmm_src_t acc_src;
    logic [6:0] acc_ofs;
    logic [7:0] acc_wdata, sfr_rdata, rd_data, sfr_wdata, working_register, q;
    logic [14:0] pc_load_val, pc;
    logic [13:0] pm_rdata;
    logic [12:0] pm_addr, pa;
    logic [11:0] sfr_addr, sfr_seen;
    logic [4:0] bank_select_register;
    logic [15:0] file_pointer0, file_pointer1;
    int err_total, samples_checked, n, sfr_n;
    cmm_core_memory_map dut (.clk_sys(clk_sys), .nrst(nrst), .pc_load(pc_load),
        .pc_load_val(pc_load_val), .pc_step(pc_step), .int_take(int_take),
        .call_push(call_push), .ret_pop(ret_pop), .acc_valid(acc_valid),
        .acc_write(acc_write), .acc_src(acc_src), .acc_ofs(acc_ofs),
        .acc_wdata(acc_wdata), .pm_rdata(pm_rdata), .sfr_rdata(sfr_rdata), .pc(pc),
        .pm_addr(pm_addr), .rd_valid(rd_valid), .rd_data(rd_data),
        .stall_cycle(stall_cycle), .sfr_sel(sfr_sel), .sfr_we(sfr_we),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .bank_select_register(bank_select_register), .file_pointer0(file_pointer0),
        .file_pointer1(file_pointer1), .working_register(working_register));
    cmm_mem_model mdl (.clk_sys(clk_sys), .nrst(nrst), .pm_addr(pm_addr),
        .sfr_sel(sfr_sel), .sfr_we(sfr_we), .sfr_addr(sfr_addr),
        .pm_rdata(pm_rdata), .sfr_rdata(sfr_rdata));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // peripheral selects are logged so decode can be judged after the access
    always @(negedge clk_sys) begin
        if (sfr_sel === 1'b1) begin
            sfr_seen <= sfr_addr;
            sfr_n <= sfr_n + 1;
        end
    end
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic chk_cnt(input int got, input int exp, input string m);
        samples_checked++;
        if (got != exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t %s count %0d exp %0d", $time, m, got, exp);
        end
    endtask
    // one data access; h keeps the request up for the extra program cycle
    task automatic acc(input cmm_src_t s, input logic [6:0] o, input logic w,
                       input logic [7:0] d, input logic h);
        acc_valid = 1'b1;
        acc_src = s;
        acc_ofs = o;
        acc_write = w;
        acc_wdata = d;
        @(negedge clk_sys);
        n = 1;
        st = stall_cycle;
        pa = pm_addr;
        if (h) begin
            @(negedge clk_sys);
            n = 2;
        end
        acc_valid = 1'b0;
        acc_write = 1'b0;
        while (n < 8 && rd_valid !== 1'b1) begin
            @(negedge clk_sys);
            n++;
        end
        q = rd_data;
        @(negedge clk_sys);
    endtask
    task automatic dwr(input logic [6:0] o, input logic [7:0] d);
        acc(CMM_SRC_DIRECT, o, 1'b1, d, 1'b0);
    endtask
    task automatic drd(input logic [6:0] o);
        acc(CMM_SRC_DIRECT, o, 1'b0, 8'h00, 1'b0);
    endtask
    task automatic t_pc();
        chk_val(pc, 16'h0000, "reset pc");
        pc_load = 1'b1;
        pc_load_val = 15'h7FFF;
        @(negedge clk_sys);
        pc_load = 1'b0;
        chk_val(pc, 16'h7FFF, "top pc");
        pc_step = 1'b1;
        @(negedge clk_sys);
        pc_step = 1'b0;
        chk_val(pc, 16'h0000, "pc wrap");
        pc_load = 1'b1;
        pc_load_val = 15'h0100;
        @(negedge clk_sys);
        call_push = 1'b1;
        pc_load_val = 15'h0200;
        @(negedge clk_sys);
        call_push = 1'b0;
        pc_load = 1'b0;
        chk_val(pc, 16'h0200, "call target");
        int_take = 1'b1;
        @(negedge clk_sys);
        int_take = 1'b0;
        chk_val(pc, 16'h0004, "int vector");
        ret_pop = 1'b1;
        @(negedge clk_sys);
        chk_val(pc, 16'h0200, "pop int");
        @(negedge clk_sys);
        ret_pop = 1'b0;
        chk_val(pc, 16'h0101, "pop call");
        $display("test pc done");
    endtask
    task automatic t_bank();
        dwr(OFS_BSR, 8'h02);
        chk_val(bank_select_register, 16'h0002, "bank sel");
        dwr(7'h20, 8'h11);
        dwr(7'h70, 8'hC3);
        dwr(OFS_BSR, 8'h03);
        dwr(7'h20, 8'h33);
        drd(7'h70);
        chk_val(q, 16'h00C3, "common ram");
        dwr(OFS_BSR, 8'h02);
        drd(7'h20);
        chk_val(q, 16'h0011, "banked ram");
        chk_cnt(n, 2, "read latency");
        dwr(OFS_BSR, 8'h14);
        dwr(7'h30, 8'hA5);
        drd(7'h30);
        chk_val(q, 16'h0000, "unimplemented");
        drd(7'h70);
        chk_val(q, 16'h00C3, "common high bank");
        $display("test bank done");
    endtask
    task automatic t_sfr();
        dwr(OFS_BSR, 8'h05);
        drd(OFS_SFR_LO);
        chk_val(sfr_seen, 16'h028C, "sfr addr lo");
        chk_val(q, 16'h00D6, "sfr data lo");
        drd(OFS_SFR_HI);
        chk_val(sfr_seen, 16'h029F, "sfr addr hi");
        chk_val(q, 16'h00C5, "sfr data hi");
        n = sfr_n;
        drd(OFS_INTCTL);
        drd(OFS_GPR_LO);
        chk_cnt(sfr_n, n, "no sfr outside");
        $display("test sfr done");
    endtask
    task automatic t_ptr();
        dwr(OFS_BSR, 8'h01);
        dwr(7'h25, 8'h5E);
        dwr(OFS_FP0H, 8'h00);
        dwr(OFS_FP0L, 8'hA5);
        chk_val(file_pointer0, 16'h00A5, "ptr0 value");
        acc(CMM_SRC_PTR0, 7'h00, 1'b0, 8'h00, 1'b0);
        chk_val(q, 16'h005E, "ptr0 banked");
        dwr(OFS_FP1H, 8'h20);
        dwr(OFS_FP1L, 8'h55);
        acc(CMM_SRC_PTR1, 7'h00, 1'b0, 8'h00, 1'b0);
        chk_val(q, 16'h005E, "ptr1 linear");
        acc(CMM_SRC_PTR1, 7'h00, 1'b1, 8'h6A, 1'b0);
        drd(7'h25);
        chk_val(q, 16'h006A, "linear write");
        $display("test ptr done");
    endtask
    task automatic t_prog();
        dwr(OFS_FP1H, 8'hFF);
        dwr(OFS_FP1L, 8'hFF);
        acc(CMM_SRC_PTR1, 7'h00, 1'b0, 8'h00, 1'b1);
        chk_val(st, 16'h0001, "extra cycle");
        chk_val(pa, 16'h1FFF, "prog wrap");
        chk_cnt(n, 2, "prog latency");
        chk_val(q, 16'h005A, "low byte");
        chk_val(working_register, 16'h005A, "working_register load");
        dwr(OFS_FP1H, 8'h81);
        dwr(OFS_FP1L, 8'h23);
        acc(CMM_SRC_PTR1, 7'h00, 1'b1, 8'h11, 1'b0);
        chk_cnt(n, 8, "prog write no answer");
        acc(CMM_SRC_PTR1, 7'h00, 1'b0, 8'h00, 1'b1);
        chk_val(pa, 16'h0123, "prog addr");
        chk_val(q, 16'h0086, "prog data");
        $display("test prog done");
    endtask
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // a few hundred cycles are expected; the limit leaves ample margin
    initial begin
        #100000;
        err_total++;
        end_of_test();
    end
    initial begin
        {nrst, pc_load, pc_step, int_take, call_push, ret_pop} = 6'h00;
        {acc_valid, acc_write, acc_ofs, acc_wdata} = 17'h00000;
        acc_src = CMM_SRC_DIRECT;
        pc_load_val = 15'h0000;
        err_total = 0;
        samples_checked = 0;
        sfr_n = 0;
        repeat (2) @(negedge clk_sys);
        nrst = 1'b1;
        t_pc();
        t_bank();
        t_sfr();
        t_ptr();
        t_prog();
        end_of_test();
    end
endmodule
